// [hdl/smcr_regs.sv]
`timescale 1ns/10ps
// Contract
// - registers other than capability header and identifiers only present in upstream port function
// - eeprom address bits 15:0, rw, reset zero
// - eeprom data bits 31:16, rw, reset zero
// - diag mode, port select, start; reset zero
// - diag value read-only, zero after reset
// - mode 0ch shows selected port training flags
// - capability id reads constant 0dh
// - next pointer reads c0h
// - subsystem vendor id read-only, loadable default
// - subsystem device id read-only, loadable default
// - bit 4n is pin input, resets one
// - bit 4n+1 direction, resets to input
// - bit 4n+2 output value, 4n+3 reserved
// - pins 0/1 owned by port power when pme
// - enabled pme: port power drives pin
module smcr_regs #(
  parameter int PORTS = 8,
  parameter logic [15:0] VENDOR_DEFAULT = 16'h0000,
  parameter logic [15:0] DEVICE_DEFAULT = 16'h0000
) (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic upstream_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic ident_load_i,
  input wire logic [15:0] vendor_load_i,
  input wire logic [15:0] device_load_i,
  input wire logic [PORTS*3-1:0] lt_state_i,
  input wire logic [1:0] pme_cap_i,
  input wire logic [1:0] port_power_i,
  input wire logic [smcr_pkg::PIN_COUNT-1:0] pin_in_i,
  output logic [smcr_pkg::PIN_COUNT-1:0] pin_out_o,
  output logic [smcr_pkg::PIN_COUNT-1:0] pin_oe_n_o,
  output logic [15:0] eeprom_addr_o,
  output logic [15:0] eeprom_data_o,
  output logic [7:0] indicator_test_byte_o
);

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  logic wr_setup;
  logic hit_eeprom;
  logic hit_diag_ctrl;
  logic hit_pin;
  logic [31:0] next_rdata;
  logic next_err;

  // single-cycle access: ready rises in the access phase after setup
  assign wr_setup = psel_i && !penable_i && pwrite_i && upstream_i;
  assign hit_eeprom = paddr_i == smcr_pkg::OFF_EEPROM_WORD;
  assign hit_diag_ctrl = paddr_i == smcr_pkg::OFF_DIAG_CONTROL;
  assign hit_pin = paddr_i == smcr_pkg::OFF_PIN_IO;

  // ----------------------------------------
  // eeprom word
  // ----------------------------------------
  logic [15:0] eeprom_addr;
  logic [15:0] eeprom_data;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      eeprom_addr <= smcr_pkg::EEPROM_ADDR_RESET;
      eeprom_data <= smcr_pkg::EEPROM_DATA_RESET;
    end else if (wr_setup && hit_eeprom) begin
      eeprom_addr <= pwdata_i[15:0];
      eeprom_data <= pwdata_i[31:16];
    end
  end

  // ----------------------------------------
  // diag control
  // ----------------------------------------
  smcr_pkg::smcr_diag_ctrl_t diag_ctrl;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      diag_ctrl <= '0;
    end else if (wr_setup && hit_diag_ctrl) begin
      diag_ctrl.mode_sel <= pwdata_i[4:0];
      diag_ctrl.port_sel <= pwdata_i[7:5];
      diag_ctrl.start <= pwdata_i[8];
      diag_ctrl.indicator_test_byte <= pwdata_i[31:24];
    end
  end

  // ----------------------------------------
  // diag value
  // ----------------------------------------
  logic [31:0] diag_value;
  logic [31:0] next_diag_value;
  logic [2:0] sel_state;
  logic [PORTS*3+2:0] lt_padded;

  // port select beyond PORTS reads as state seven (other), which sets no flags
  assign lt_padded = {3'h0, lt_state_i};
  assign sel_state = (int'(diag_ctrl.port_sel) < PORTS) ?
                     lt_padded[diag_ctrl.port_sel*3 +: 3] : 3'h7;

  always_comb begin
    next_diag_value = smcr_pkg::DIAG_VALUE_RESET;
    if (diag_ctrl.start && diag_ctrl.mode_sel == smcr_pkg::DIAG_MODE_LTSSM) begin
      case (smcr_pkg::smcr_lt_state_t'(sel_state))
        smcr_pkg::smcr_lt_detect: next_diag_value[smcr_pkg::LT_DETECT] = 1'b1;
        smcr_pkg::smcr_lt_config: next_diag_value[smcr_pkg::LT_CONFIG] = 1'b1;
        smcr_pkg::smcr_lt_l0: next_diag_value[smcr_pkg::LT_L0] = 1'b1;
        smcr_pkg::smcr_lt_l2: next_diag_value[smcr_pkg::LT_L2] = 1'b1;
        smcr_pkg::smcr_lt_disabled: next_diag_value[smcr_pkg::LT_DISABLED] = 1'b1;
        smcr_pkg::smcr_lt_loopback: next_diag_value[smcr_pkg::LT_LOOP_RECOV] = 1'b1;
        smcr_pkg::smcr_lt_recovery: next_diag_value[smcr_pkg::LT_LOOP_RECOV] = 1'b1;
        default: next_diag_value = smcr_pkg::DIAG_VALUE_RESET;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      diag_value <= smcr_pkg::DIAG_VALUE_RESET;
    end else begin
      diag_value <= next_diag_value;
    end
  end

  // ----------------------------------------
  // subsystem identifiers
  // ----------------------------------------
  logic [15:0] vendor_ident;
  logic [15:0] device_ident;

  // loadable by autoload or sideband before software reads; bus cannot write
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      vendor_ident <= VENDOR_DEFAULT;
      device_ident <= DEVICE_DEFAULT;
    end else if (ident_load_i) begin
      vendor_ident <= vendor_load_i;
      device_ident <= device_load_i;
    end
  end

  // ----------------------------------------
  // pin control, one slice per pin
  // ----------------------------------------
  logic [smcr_pkg::PIN_COUNT-1:0] pin_meta;
  logic [smcr_pkg::PIN_COUNT-1:0] pin_sync;
  logic [smcr_pkg::PIN_COUNT-1:0] pin_dir;
  logic [smcr_pkg::PIN_COUNT-1:0] pin_val;
  logic [31:0] pin_word;

  genvar gi;
  generate
    for (gi = 0; gi < smcr_pkg::PIN_COUNT; gi = gi + 1) begin : g_pin
      logic owned;
      // only pins 0 and 1 can be taken by a port's power control
      if (gi < 2) begin : g_pme
        assign owned = pme_cap_i[gi];
      end else begin : g_free
        assign owned = 1'b0;
      end

      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          pin_meta[gi] <= smcr_pkg::PIN_IN_RESET;
          pin_sync[gi] <= smcr_pkg::PIN_IN_RESET;
        end else begin
          pin_meta[gi] <= pin_in_i[gi];
          pin_sync[gi] <= pin_meta[gi];
        end
      end

      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          pin_dir[gi] <= 1'b0;
          pin_val[gi] <= 1'b0;
        end else if (wr_setup && hit_pin) begin
          pin_dir[gi] <= pwdata_i[gi*smcr_pkg::PIN_FIELD + smcr_pkg::PIN_DIR_BIT];
          pin_val[gi] <= pwdata_i[gi*smcr_pkg::PIN_FIELD + smcr_pkg::PIN_OUT_BIT];
        end
      end

      always_ff @(posedge clk_i) begin
        if (srst_i) begin
          pin_out_o[gi] <= 1'b0;
          pin_oe_n_o[gi] <= 1'b1;
        end else if (owned && gi < 2) begin
          pin_out_o[gi] <= port_power_i[gi % 2];
          pin_oe_n_o[gi] <= 1'b0;
        end else begin
          pin_out_o[gi] <= pin_val[gi];
          pin_oe_n_o[gi] <= ~pin_dir[gi];
        end
      end

      assign pin_word[gi*smcr_pkg::PIN_FIELD +: smcr_pkg::PIN_FIELD] =
        {1'b0, pin_val[gi], pin_dir[gi], pin_sync[gi]};
    end
  endgenerate

  assign pin_word[31:smcr_pkg::PIN_COUNT*smcr_pkg::PIN_FIELD] = '0;

  // ----------------------------------------
  // read mux and answer
  // ----------------------------------------
  always_comb begin
    next_rdata = 32'h00000000;
    next_err = 1'b0;
    // capability header and identifiers stay visible in every port function
    if (paddr_i == smcr_pkg::OFF_SUBSYS_CAP) begin
      next_rdata = {16'h0000, smcr_pkg::CAP_NEXT_RESET, smcr_pkg::CAP_ID_SUBSYS};
    end else if (paddr_i == smcr_pkg::OFF_SUBSYS_IDENT) begin
      next_rdata = {device_ident, vendor_ident};
    end else if (!upstream_i) begin
      next_err = 1'b0;
    end else if (paddr_i == smcr_pkg::OFF_EEPROM_WORD) begin
      next_rdata = {eeprom_data, eeprom_addr};
    end else if (paddr_i == smcr_pkg::OFF_DIAG_CONTROL) begin
      next_rdata = {23'h000000, diag_ctrl.start, diag_ctrl.port_sel, diag_ctrl.mode_sel};
    end else if (paddr_i == smcr_pkg::OFF_DIAG_VALUE) begin
      next_rdata = diag_value;
    end else if (paddr_i == smcr_pkg::OFF_PIN_IO) begin
      next_rdata = pin_word;
    end else begin
      next_err = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && !penable_i;
      prdata_o <= (psel_i && !penable_i && !pwrite_i) ? next_rdata : 32'h00000000;
      pslverr_o <= psel_i && !penable_i && next_err;
    end
  end

  // ----------------------------------------
  // outputs to the eeprom engine
  // ----------------------------------------
  // engine launches from the control word; address and data loaded first
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      eeprom_addr_o <= smcr_pkg::EEPROM_ADDR_RESET;
      eeprom_data_o <= smcr_pkg::EEPROM_DATA_RESET;
      indicator_test_byte_o <= 8'h00;
    end else begin
      eeprom_addr_o <= eeprom_addr;
      eeprom_data_o <= eeprom_data;
      indicator_test_byte_o <= diag_ctrl.indicator_test_byte;
    end
  end

endmodule : smcr_regs

// [common/smcr_pkg.sv]
package smcr_pkg;

  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_EEPROM_WORD = 8'ha4;
  localparam logic [7:0] OFF_DIAG_CONTROL = 8'ha8;
  localparam logic [7:0] OFF_DIAG_VALUE = 8'hac;
  localparam logic [7:0] OFF_SUBSYS_CAP = 8'hb0;
  localparam logic [7:0] OFF_SUBSYS_IDENT = 8'hb4;
  localparam logic [7:0] OFF_PIN_IO = 8'hb8;

  // ----------------------------------------
  // field values and reset values
  // ----------------------------------------
  localparam logic [15:0] EEPROM_ADDR_RESET = 16'h0000;
  localparam logic [15:0] EEPROM_DATA_RESET = 16'h0000;
  localparam logic [4:0] DIAG_MODE_LTSSM = 5'h0c;
  localparam logic [7:0] CAP_ID_SUBSYS = 8'h0d;
  localparam logic [7:0] CAP_NEXT_RESET = 8'hc0;
  localparam logic [31:0] DIAG_VALUE_RESET = 32'h00000000;
  localparam int PIN_COUNT = 4;
  localparam int PIN_FIELD = 4;
  localparam int PIN_IN_BIT = 0;
  localparam int PIN_DIR_BIT = 1;
  localparam int PIN_OUT_BIT = 2;
  localparam logic PIN_IN_RESET = 1'b1;

  // link training state flags
  localparam int LT_DETECT = 0;
  localparam int LT_CONFIG = 1;
  localparam int LT_L0 = 3;
  localparam int LT_L2 = 5;
  localparam int LT_DISABLED = 6;
  localparam int LT_LOOP_RECOV = 9;

  typedef enum logic [2:0] {
    smcr_lt_detect,
    smcr_lt_config,
    smcr_lt_l0,
    smcr_lt_l2,
    smcr_lt_disabled,
    smcr_lt_loopback,
    smcr_lt_recovery,
    smcr_lt_other
  } smcr_lt_state_t;

  typedef struct packed {
    logic [7:0] indicator_test_byte;
    logic start;
    logic [2:0] port_sel;
    logic [4:0] mode_sel;
  } smcr_diag_ctrl_t;

endpackage : smcr_pkg

// [tb/smcr_regs_sva.sv]
`timescale 1ns/10ps
module smcr_regs_sva (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic upstream_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  input wire logic [1:0] pme_cap_i,
  input wire logic [1:0] port_power_i,
  input wire logic [smcr_pkg::PIN_COUNT-1:0] pin_out_o,
  input wire logic [smcr_pkg::PIN_COUNT-1:0] pin_oe_n_o,
  input wire logic [15:0] eeprom_addr_o,
  input wire logic [15:0] eeprom_data_o
);
  // ----
  // register side checks
  // ----
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  sequence s_acc(w, a);
    psel_i && !penable_i && pwrite_i == w && paddr_i == a && upstream_i;
  endsequence
  property p_down;
    psel_i && !penable_i && !upstream_i && paddr_i != smcr_pkg::OFF_SUBSYS_CAP &&
      paddr_i != smcr_pkg::OFF_SUBSYS_IDENT |=> prdata_o == 32'h0 && !pslverr_o;
  endproperty
  property p_capid; s_acc(0, smcr_pkg::OFF_SUBSYS_CAP) |=> prdata_o[7:0] == smcr_pkg::CAP_ID_SUBSYS; endproperty
  property p_next; s_acc(0, smcr_pkg::OFF_SUBSYS_CAP) |=> prdata_o[15:8] == smcr_pkg::CAP_NEXT_RESET; endproperty
  property p_pinrsv; s_acc(0, smcr_pkg::OFF_PIN_IO) |=> (prdata_o & 32'hffff8888) == 32'h0; endproperty
  property p_ctlrsv; s_acc(0, smcr_pkg::OFF_DIAG_CONTROL) |=> prdata_o[31:9] == 23'h0; endproperty
  property p_addr; s_acc(1, smcr_pkg::OFF_EEPROM_WORD) |-> ##2 eeprom_addr_o == 16'($past(pwdata_i, 2)); endproperty
  property p_data;
    s_acc(1, smcr_pkg::OFF_EEPROM_WORD) |-> ##2 {eeprom_data_o, 16'h0} == ($past(pwdata_i, 2) & 32'hffff0000);
  endproperty
  property p_pme; &pme_cap_i |=> pin_oe_n_o[1:0] == 2'b00 && pin_out_o[1:0] == $past(port_power_i); endproperty
  a_down: assert property (p_down) else $error("downstream access answered");
  a_capid: assert property (p_capid) else $error("bad capability id");
  a_next: assert property (p_next) else $error("bad next pointer");
  a_pinrsv: assert property (p_pinrsv) else $error("pin reserved bits set");
  a_ctlrsv: assert property (p_ctlrsv) else $error("control reserved bits set");
  a_addr: assert property (p_addr) else $error("eeprom address not stored");
  a_data: assert property (p_data) else $error("eeprom data not stored");
  a_pme: assert property (p_pme) else $error("port power not on pins");
endmodule : smcr_regs_sva
bind smcr_regs smcr_regs_sva u_sva (.clk_i(clk_i), .srst_i(srst_i), .upstream_i(upstream_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pslverr_o(pslverr_o), .pme_cap_i(pme_cap_i), .port_power_i(port_power_i), .pin_out_o(pin_out_o),
  .pin_oe_n_o(pin_oe_n_o), .eeprom_addr_o(eeprom_addr_o), .eeprom_data_o(eeprom_data_o));

// [tb/switch_misc_config_registers_bench.sv]
`timescale 1ns/10ps
module switch_misc_config_registers_bench;
  // ----
  // bench
  // ----
  logic clk_i, srst_i, upstream_i, psel_i, penable_i, pwrite_i, ident_load_i, pready_o, pslverr_o, err;
  logic [7:0] paddr_i, indicator_test_byte_o;
  logic [31:0] pwdata_i, prdata_o, rd;
  logic [15:0] vendor_load_i, device_load_i, eeprom_addr_o, eeprom_data_o;
  logic [23:0] lt_state_i;
  logic [1:0] pme_cap_i, port_power_i;
  logic [3:0] pin_in_i, pin_out_o, pin_oe_n_o;
  int n_fail = 0;
  int samples_checked = 0;
  int lt_bit [7] = '{0, 1, 3, 5, 6, 9, 9};
  smcr_regs dut (.clk_i(clk_i), .srst_i(srst_i), .upstream_i(upstream_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .ident_load_i(ident_load_i), .vendor_load_i(vendor_load_i),
    .device_load_i(device_load_i), .lt_state_i(lt_state_i), .pme_cap_i(pme_cap_i), .port_power_i(port_power_i),
    .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oe_n_o(pin_oe_n_o), .eeprom_addr_o(eeprom_addr_o),
    .eeprom_data_o(eeprom_data_o), .indicator_test_byte_o(indicator_test_byte_o));
  initial begin
    clk_i = 0;
    forever #12.5 clk_i = ~clk_i;
  end
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task conclude;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  // one apb transfer, entered just after a rising edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel_i <= 1;
    penable_i <= 0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    if (pready_o !== 1'b1) begin
      n_fail++;
      conclude();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    @(posedge clk_i);
  endtask : bus
  task rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
    bus(0, a, 32'h0);
    check(n, rd, e);
  endtask : rdchk
  initial begin
    {srst_i, upstream_i, psel_i, penable_i, pwrite_i, ident_load_i} = 6'h30;
    {paddr_i, pwdata_i, vendor_load_i, device_load_i, lt_state_i, pme_cap_i, port_power_i} = '0;
    pin_in_i = 4'hf;
    repeat (5) @(posedge clk_i);
    srst_i <= 0;
    @(posedge clk_i);
    rdchk(smcr_pkg::OFF_EEPROM_WORD, 32'h0, "eeprom word");
    rdchk(smcr_pkg::OFF_DIAG_CONTROL, 32'h0, "diag control");
    rdchk(smcr_pkg::OFF_PIN_IO, 32'h00001111, "pin io");
    bus(1, smcr_pkg::OFF_DIAG_VALUE, '1);
    bus(1, smcr_pkg::OFF_SUBSYS_CAP, '1);
    bus(1, smcr_pkg::OFF_SUBSYS_IDENT, '1);
    rdchk(smcr_pkg::OFF_DIAG_VALUE, 32'h0, "diag value");
    rdchk(smcr_pkg::OFF_SUBSYS_CAP, 32'h0000c00d, "cap header");
    rdchk(smcr_pkg::OFF_SUBSYS_IDENT, 32'h0, "ident");
    bus(1, smcr_pkg::OFF_EEPROM_WORD, 32'h1234abcd);
    rdchk(smcr_pkg::OFF_EEPROM_WORD, 32'h1234abcd, "eeprom word");
    check("eeprom outs", {eeprom_data_o, eeprom_addr_o}, 32'h1234abcd);
    bus(1, smcr_pkg::OFF_DIAG_CONTROL, '1);
    rdchk(smcr_pkg::OFF_DIAG_CONTROL, 32'h000001ff, "diag control");
    check("indicator", {24'h0, indicator_test_byte_o}, 32'hff);
    rdchk(smcr_pkg::OFF_DIAG_VALUE, 32'h0, "diag other mode");
    bus(1, smcr_pkg::OFF_DIAG_CONTROL, 32'h0000014c);
    for (int c = 0; c < 7; c++) begin
      lt_state_i <= 24'(c) << 6;
      @(posedge clk_i);
      rdchk(smcr_pkg::OFF_DIAG_VALUE, 32'h1 << lt_bit[c], "training flags");
    end
    {ident_load_i, vendor_load_i, device_load_i} <= {1'b1, 16'h5a5a, 16'ha5c3};
    @(posedge clk_i);
    ident_load_i <= 0;
    rdchk(smcr_pkg::OFF_SUBSYS_IDENT, 32'ha5c35a5a, "ident load");
    pin_in_i <= 4'b0101;
    bus(1, smcr_pkg::OFF_PIN_IO, '1);
    repeat (3) @(posedge clk_i);
    rdchk(smcr_pkg::OFF_PIN_IO, 32'h00006767, "pin io");
    check("pin oe", {28'h0, pin_oe_n_o}, 32'h0);
    check("pin out", {28'h0, pin_out_o}, 32'hf);
    {pme_cap_i, port_power_i} <= 4'b1110;
    bus(1, smcr_pkg::OFF_PIN_IO, 32'h00006600);
    @(posedge clk_i);
    check("pme out", {28'h0, pin_out_o}, 32'he);
    check("pme oe", {28'h0, pin_oe_n_o}, 32'h0);
    pme_cap_i <= 2'b00;
    repeat (2) @(posedge clk_i);
    check("no pme oe", {28'h0, pin_oe_n_o}, 32'h3);
    check("no pme out", {28'h0, pin_out_o}, 32'hc);
    bus(0, 8'hc0, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    upstream_i <= 0;
    bus(1, smcr_pkg::OFF_EEPROM_WORD, 32'h55555555);
    rdchk(smcr_pkg::OFF_EEPROM_WORD, 32'h0, "downstream");
    check("downstream err", {31'h0, err}, 32'h0);
    rdchk(smcr_pkg::OFF_SUBSYS_CAP, 32'h0000c00d, "downstream cap");
    upstream_i <= 1;
    rdchk(smcr_pkg::OFF_EEPROM_WORD, 32'h1234abcd, "kept word");
    conclude();
  end
endmodule : switch_misc_config_registers_bench
